// ---- design/msc_defines.vh ----
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

// register byte addresses
`define MSC_STARTUP_CONFIG_A_ADDR 8'h84
`define MSC_STATUS_ADDR           8'h88
`define MSC_STARTUP_CONFIG_A_RST  32'h00000000
`define MSC_STARTUP_CONFIG_A_MASK 32'h7fffffff

// field positions of startup_config_a
`define MSC_METHOD_HI      30
`define MSC_METHOD_LO      29
`define MSC_RAMP_HI        28
`define MSC_RAMP_LO        25
`define MSC_ALIGN_HI       24
`define MSC_ALIGN_LO       21
`define MSC_CAP_HI         20
`define MSC_CAP_LO         17
`define MSC_PRATE_HI       16
`define MSC_PRATE_LO       14
`define MSC_PTHR_HI        13
`define MSC_PTHR_LO        9
`define MSC_PRELEASE_BIT   8
`define MSC_PADV_HI        7
`define MSC_PADV_LO        6
`define MSC_PREP_HI        5
`define MSC_PREP_LO        4
`define MSC_OLSRC_BIT      3
`define MSC_IQRAMP_BIT     2
`define MSC_BRAKE_BIT      1
`define MSC_REVPROF_BIT    0

// status bits
`define MSC_ST_THR_INVALID 0
`define MSC_ST_PROBE_ACT   1

// start-up method codes
`define MSC_M_ALIGN        2'h0
`define MSC_M_DOUBLE_ALIGN 2'h1
`define MSC_M_PROBE        2'h2
`define MSC_M_SLOW_CYCLE   2'h3

// highest defined probe threshold code
`define MSC_PTHR_MAX       5'h11

// timing
`define MSC_CLK_HZ         50000000
`define MSC_CLK_PERIOD_NS  20

// axi responses
`define MSC_RESP_OKAY      2'h0
`define MSC_RESP_DECERR    2'h3

`endif

// ---- design/msc_startup_config.v ----
`timescale 1ns/100ps
`include "msc_defines.vh"

module msc_startup_config #(
  parameter ADDR_W = 8,
  parameter CLK_HZ = `MSC_CLK_HZ
) (
  input  wire        ref_clk,                  // 50 MHz clock
  input  wire        rst,                      // async reset, high
  input  wire [ADDR_W-1:0] s_axi_awaddr,       // write address
  input  wire        s_axi_awvalid,            // write address valid
  output reg         s_axi_awready,            // write address ready
  input  wire [31:0] s_axi_wdata,              // write data
  input  wire [3:0]  s_axi_wstrb,              // write byte strobes
  input  wire        s_axi_wvalid,             // write data valid
  output reg         s_axi_wready,             // write data ready
  output reg  [1:0]  s_axi_bresp,              // write response
  output reg         s_axi_bvalid,             // write response valid
  input  wire        s_axi_bready,             // write response ready
  input  wire [ADDR_W-1:0] s_axi_araddr,       // read address
  input  wire        s_axi_arvalid,            // read address valid
  output reg         s_axi_arready,            // read address ready
  output reg  [31:0] s_axi_rdata,              // read data
  output reg  [1:0]  s_axi_rresp,              // read response
  output reg         s_axi_rvalid,             // read data valid
  input  wire        s_axi_rready,             // read data ready
  input  wire [3:0]  open_loop_current_cap,    // dedicated limit code
  input  wire [6:0]  general_current_cap,      // general limit, 5/64 A
  input  wire        probe_run,                // probe sequence active
  output reg  [3:0]  startup_method_onehot,    // align,dbl,probe,slow
  output reg  [15:0] current_ramp_rate,        // slope in 0.1 A/s
  output reg         current_ramp_unlimited,   // no slope limit
  output reg  [13:0] align_time_ms,            // align hold in ms
  output reg  [6:0]  startup_current_cap,      // cap in 5/64 A
  output reg  [13:0] probe_pulse_rate,         // probe rate in Hz
  output reg         probe_tick,               // one pulse per period
  output reg  [12:0] probe_current_threshold,  // threshold in mA
  output reg         probe_thr_invalid,        // undefined code
  output reg         probe_release_mode,       // 1 floats, 0 brakes
  output reg  [6:0]  probe_advance_angle,      // degrees
  output reg  [2:0]  probe_repeat_count,       // runs to average
  output reg  [6:0]  open_loop_limit,          // cap in 5/64 A
  output reg         open_loop_limit_source,   // 1 general cap
  output reg         torque_current_rampdown_en, // ramp iq down
  output reg         active_brake_en,          // brake by reverse drive
  output reg         reverse_profile_sel       // 1 reverse values
);

  // current step table in units of 0.078125 A, shared by both caps
  function [6:0] cap_units;
    input [3:0] code;
    begin
      case (code)
        4'h0: cap_units = 7'h01;
        4'h1: cap_units = 7'h02;
        4'h2: cap_units = 7'h04;
        4'h3: cap_units = 7'h08;
        4'h4: cap_units = 7'h0c;
        4'h5: cap_units = 7'h10;
        4'h6: cap_units = 7'h14;
        4'h7: cap_units = 7'h18;
        4'h8: cap_units = 7'h1c;
        4'h9: cap_units = 7'h20;
        4'ha: cap_units = 7'h24;
        4'hb: cap_units = 7'h28;
        4'hc: cap_units = 7'h2c;
        4'hd: cap_units = 7'h30;
        4'he: cap_units = 7'h38;
        default: cap_units = 7'h40;
      endcase
    end
  endfunction

  // probe rate in Hz, used for both the output and the divider
  function [13:0] rate_hz;
    input [2:0] code;
    begin
      case (code)
        3'h0: rate_hz = 14'd50;
        3'h1: rate_hz = 14'd100;
        3'h2: rate_hz = 14'd250;
        3'h3: rate_hz = 14'd500;
        3'h4: rate_hz = 14'd1000;
        3'h5: rate_hz = 14'd2000;
        3'h6: rate_hz = 14'd5000;
        default: rate_hz = 14'd10000;
      endcase
    end
  endfunction

  reg [31:0]       cfg_reg;
  reg [ADDR_W-1:0] awaddr_reg;
  reg [31:0]       wdata_reg;
  reg [3:0]        wstrb_reg;
  reg              aw_held_reg;
  reg              w_held_reg;
  reg [19:0]       div_cnt_reg;
  reg [31:0]       wmask;
  reg [31:0]       rd_word;
  wire [19:0]      div_period;
  wire [31:0]      div_full;
  wire             do_write;

  // write only once both address and data are held
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always @*
  begin
    wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
             {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  end

  always @*
  begin
    rd_word = 32'h00000000;
    if (s_axi_araddr == `MSC_STARTUP_CONFIG_A_ADDR)
      rd_word = cfg_reg;
    else if (s_axi_araddr == `MSC_STATUS_ADDR)
    begin
      rd_word[`MSC_ST_THR_INVALID] = probe_thr_invalid;
      rd_word[`MSC_ST_PROBE_ACT]   = probe_run;
    end
  end

  // write channel
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MSC_RESP_OKAY;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= {ADDR_W{1'b0}};
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      cfg_reg       <= `MSC_STARTUP_CONFIG_A_RST;
    end
    else
    begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_bvalid &
                       ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_reg & ~s_axi_bvalid &
                       ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready)
      begin
        awaddr_reg  <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_held_reg <= 1'b1;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_reg == `MSC_STARTUP_CONFIG_A_ADDR)
        begin
          s_axi_bresp <= `MSC_RESP_OKAY;
          cfg_reg <= ((cfg_reg & ~wmask) | (wdata_reg & wmask)) &
                     `MSC_STARTUP_CONFIG_A_MASK;
        end
        else if (awaddr_reg == `MSC_STATUS_ADDR)
          s_axi_bresp <= `MSC_RESP_OKAY;
        else
          s_axi_bresp <= `MSC_RESP_DECERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, data one cycle after the address is taken
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MSC_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      if (s_axi_araddr == `MSC_STARTUP_CONFIG_A_ADDR ||
          s_axi_araddr == `MSC_STATUS_ADDR)
        s_axi_rresp <= `MSC_RESP_OKAY;
      else
        s_axi_rresp <= `MSC_RESP_DECERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (~s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // divider period, 20 bits cover 50 Hz at 50 MHz
  assign div_full   = CLK_HZ / rate_hz(cfg_reg[`MSC_PRATE_HI:`MSC_PRATE_LO]);
  assign div_period = div_full[19:0];

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt_reg <= 20'h00000;
      probe_tick  <= 1'b0;
    end
    else if (~probe_run)
    begin
      div_cnt_reg <= 20'h00000;
      probe_tick  <= 1'b0;
    end
    else if (div_cnt_reg + 20'h00001 >= div_period)
    begin
      div_cnt_reg <= 20'h00000;
      probe_tick  <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 20'h00001;
      probe_tick  <= 1'b0;
    end
  end

  // decoded settings, registered one cycle behind the word
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      startup_method_onehot      <= 4'h1;
      current_ramp_rate          <= 16'd1;
      current_ramp_unlimited     <= 1'b0;
      align_time_ms              <= 14'd10;
      startup_current_cap        <= 7'h01;
      probe_pulse_rate           <= 14'd50;
      probe_current_threshold    <= 13'd156;
      probe_thr_invalid          <= 1'b0;
      probe_release_mode         <= 1'b0;
      probe_advance_angle        <= 7'd0;
      probe_repeat_count         <= 3'd1;
      open_loop_limit            <= 7'h01;
      open_loop_limit_source     <= 1'b0;
      torque_current_rampdown_en <= 1'b0;
      active_brake_en            <= 1'b0;
      reverse_profile_sel        <= 1'b0;
    end
    else
    begin
      case (cfg_reg[`MSC_METHOD_HI:`MSC_METHOD_LO])
        `MSC_M_ALIGN:        startup_method_onehot <= 4'h1;
        `MSC_M_DOUBLE_ALIGN: startup_method_onehot <= 4'h2;
        `MSC_M_PROBE:        startup_method_onehot <= 4'h4;
        default:             startup_method_onehot <= 4'h8;
      endcase
      current_ramp_unlimited <= &cfg_reg[`MSC_RAMP_HI:`MSC_RAMP_LO];
      case (cfg_reg[`MSC_RAMP_HI:`MSC_RAMP_LO])
        4'h0: current_ramp_rate <= 16'd1;
        4'h1: current_ramp_rate <= 16'd10;
        4'h2: current_ramp_rate <= 16'd50;
        4'h3: current_ramp_rate <= 16'd100;
        4'h4: current_ramp_rate <= 16'd150;
        4'h5: current_ramp_rate <= 16'd250;
        4'h6: current_ramp_rate <= 16'd500;
        4'h7: current_ramp_rate <= 16'd1000;
        4'h8: current_ramp_rate <= 16'd1500;
        4'h9: current_ramp_rate <= 16'd2000;
        4'ha: current_ramp_rate <= 16'd2500;
        4'hb: current_ramp_rate <= 16'd5000;
        4'hc: current_ramp_rate <= 16'd10000;
        4'hd: current_ramp_rate <= 16'd20000;
        4'he: current_ramp_rate <= 16'd50000;
        default: current_ramp_rate <= 16'hffff;
      endcase
      case (cfg_reg[`MSC_ALIGN_HI:`MSC_ALIGN_LO])
        4'h0: align_time_ms <= 14'd10;
        4'h1: align_time_ms <= 14'd50;
        4'h2: align_time_ms <= 14'd100;
        4'h3: align_time_ms <= 14'd200;
        4'h4: align_time_ms <= 14'd300;
        4'h5: align_time_ms <= 14'd400;
        4'h6: align_time_ms <= 14'd500;
        4'h7: align_time_ms <= 14'd750;
        4'h8: align_time_ms <= 14'd1000;
        4'h9: align_time_ms <= 14'd1500;
        4'ha: align_time_ms <= 14'd2000;
        4'hb: align_time_ms <= 14'd3000;
        4'hc: align_time_ms <= 14'd4000;
        4'hd: align_time_ms <= 14'd5000;
        4'he: align_time_ms <= 14'd7500;
        default: align_time_ms <= 14'd10000;
      endcase
      startup_current_cap <= cap_units(cfg_reg[`MSC_CAP_HI:`MSC_CAP_LO]);
      probe_pulse_rate <= rate_hz(cfg_reg[`MSC_PRATE_HI:`MSC_PRATE_LO]);
      // threshold in mA, undefined codes flagged and zeroed
      probe_thr_invalid <=
        cfg_reg[`MSC_PTHR_HI:`MSC_PTHR_LO] > `MSC_PTHR_MAX;
      case (cfg_reg[`MSC_PTHR_HI:`MSC_PTHR_LO])
        5'h00: probe_current_threshold <= 13'd156;
        5'h01: probe_current_threshold <= 13'd312;
        5'h02: probe_current_threshold <= 13'd468;
        5'h03: probe_current_threshold <= 13'd625;
        5'h04: probe_current_threshold <= 13'd781;
        5'h05: probe_current_threshold <= 13'd937;
        5'h06: probe_current_threshold <= 13'd1250;
        5'h07: probe_current_threshold <= 13'd1562;
        5'h08: probe_current_threshold <= 13'd1875;
        5'h09: probe_current_threshold <= 13'd2291;
        5'h0a: probe_current_threshold <= 13'd2500;
        5'h0b: probe_current_threshold <= 13'd2916;
        5'h0c: probe_current_threshold <= 13'd3125;
        5'h0d: probe_current_threshold <= 13'd3333;
        5'h0e: probe_current_threshold <= 13'd3750;
        5'h0f: probe_current_threshold <= 13'd4166;
        5'h10: probe_current_threshold <= 13'd4583;
        5'h11: probe_current_threshold <= 13'd5000;
        default: probe_current_threshold <= 13'd0;
      endcase
      probe_release_mode <= cfg_reg[`MSC_PRELEASE_BIT];
      case (cfg_reg[`MSC_PADV_HI:`MSC_PADV_LO])
        2'h0: probe_advance_angle <= 7'd0;
        2'h1: probe_advance_angle <= 7'd30;
        2'h2: probe_advance_angle <= 7'd60;
        default: probe_advance_angle <= 7'd90;
      endcase
      probe_repeat_count <=
        {1'b0, cfg_reg[`MSC_PREP_HI:`MSC_PREP_LO]} + 3'd1;
      open_loop_limit_source <= cfg_reg[`MSC_OLSRC_BIT];
      if (cfg_reg[`MSC_OLSRC_BIT])
        open_loop_limit <= general_current_cap;
      else
        open_loop_limit <= cap_units(open_loop_current_cap);
      torque_current_rampdown_en <= cfg_reg[`MSC_IQRAMP_BIT];
      active_brake_en <= cfg_reg[`MSC_BRAKE_BIT];
      reverse_profile_sel <= cfg_reg[`MSC_REVPROF_BIT];
    end
  end

endmodule // msc_startup_config

// ---- verification/msc_startup_config_props.sv ----
`timescale 1ns/100ps

module msc_startup_config_props #(
  parameter ADDR_W = 8
) (
  input wire logic              ref_clk,                    // clock
  input wire logic              rst,                        // reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr,               // aw addr
  input wire logic              s_axi_awvalid,              // aw valid
  input wire logic              s_axi_awready,              // aw ready
  input wire logic [31:0]       s_axi_wdata,                // w data
  input wire logic [3:0]        s_axi_wstrb,                // w strobes
  input wire logic              s_axi_wvalid,               // w valid
  input wire logic              s_axi_wready,               // w ready
  input wire logic              s_axi_bvalid,               // b valid
  input wire logic [31:0]       s_axi_rdata,                // r data
  input wire logic              s_axi_rvalid,               // r valid
  input wire logic [6:0]        general_current_cap,        // general cap
  input wire logic              probe_run,                  // probe active
  input wire logic [3:0]        startup_method_onehot,      // method
  input wire logic              current_ramp_unlimited,     // no limit
  input wire logic              probe_tick,                 // probe pulse
  input wire logic [12:0]       probe_current_threshold,    // mA
  input wire logic              probe_thr_invalid,          // bad code
  input wire logic              probe_release_mode,         // release
  input wire logic [2:0]        probe_repeat_count,         // runs
  input wire logic [6:0]        open_loop_limit,            // ol cap
  input wire logic              open_loop_limit_source,     // ol source
  input wire logic              torque_current_rampdown_en, // iq ramp
  input wire logic              active_brake_en,            // brake
  input wire logic              reverse_profile_sel         // rev profile
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // full-word write to the config register, both channels at once
  sequence s_cfg_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr == 8'h84 && s_axi_wstrb == 4'hf;
  endsequence

  sequence s_quiet;
    !probe_tick [*8];
  endsequence

  a_method_decode: assert property (
    s_cfg_wr |-> ##3 startup_method_onehot ==
      4'h1 << $past(s_axi_wdata[30:29], 3))
    else $error("start-up method decode wrong");
  a_ramp_unlimited: assert property (
    s_cfg_wr |-> ##3 current_ramp_unlimited ==
      ($past(s_axi_wdata[28:25], 3) == 4'hf))
    else $error("ramp limit flag wrong");
  a_release_repeat: assert property (
    s_cfg_wr |-> ##3 probe_release_mode == $past(s_axi_wdata[8], 3) &&
      probe_repeat_count == {1'b0, $past(s_axi_wdata[5:4], 3)} + 3'h1)
    else $error("probe release or repeat wrong");
  a_ctrl_bits: assert property (
    s_cfg_wr |-> ##3 {torque_current_rampdown_en, active_brake_en,
      reverse_profile_sel} == $past(s_axi_wdata[2:0], 3))
    else $error("control bits wrong");
  a_thr_pair: assert property (
    probe_thr_invalid == (probe_current_threshold == 13'h0000))
    else $error("threshold and invalid flag disagree");
  a_ol_source: assert property (
    (open_loop_limit_source && $stable(general_current_cap)) [*3] |->
      open_loop_limit == general_current_cap)
    else $error("open-loop limit not from general cap");
  a_tick_gap: assert property (
    probe_tick |=> s_quiet)
    else $error("probe pulses too close");
  a_tick_idle: assert property (
    !$past(probe_run) |-> !probe_tick)
    else $error("probe pulse while idle");
  a_write_answer: assert property (
    s_cfg_wr |=> (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  a_rsv_bit: assert property (
    s_axi_rvalid |-> !s_axi_rdata[31])
    else $error("reserved bit reads one");
  a_reset_state: assert property (
    $fell(rst) |-> startup_method_onehot == 4'h1 &&
      probe_repeat_count == 3'h1 && probe_current_threshold == 13'h009c)
    else $error("reset decode wrong");
endmodule // msc_startup_config_props

// ---- verification/msc_startup_config_bench.sv ----
`timescale 1ns/100ps

module msc_startup_config_bench;
  localparam int    PCLK = 100000;
  logic             ref_clk = 1'b0, rst = 1'b1, probe_run = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]       s_axi_wstrb = 4'h0, open_loop_current_cap = 4'h0;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic             s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic             s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic             s_axi_bvalid, s_axi_arready, s_axi_rvalid, probe_tick;
  logic             current_ramp_unlimited, probe_thr_invalid;
  logic             probe_release_mode, open_loop_limit_source;
  logic             torque_current_rampdown_en, active_brake_en;
  logic             reverse_profile_sel;
  logic [6:0]       general_current_cap = 7'h00, startup_current_cap;
  logic [6:0]       probe_advance_angle, open_loop_limit;
  logic [3:0]       startup_method_onehot;
  logic [15:0]      current_ramp_rate;
  logic [13:0]      align_time_ms, probe_pulse_rate;
  logic [12:0]      probe_current_threshold;
  logic [2:0]       probe_repeat_count;
  int               fail_count = 0, compares = 0;
  // ramp in 0.1 A/s, align in ms, caps in 5/64 A, rate in Hz, thr in mA
  logic [15:0] ramp_t [16] = '{16'h0001, 16'h000a, 16'h0032, 16'h0064,
    16'h0096, 16'h00fa, 16'h01f4, 16'h03e8, 16'h05dc, 16'h07d0, 16'h09c4,
    16'h1388, 16'h2710, 16'h4e20, 16'hc350, 16'hffff};
  logic [13:0] align_t [16] = '{14'h000a, 14'h0032, 14'h0064, 14'h00c8,
    14'h012c, 14'h0190, 14'h01f4, 14'h02ee, 14'h03e8, 14'h05dc, 14'h07d0,
    14'h0bb8, 14'h0fa0, 14'h1388, 14'h1d4c, 14'h2710};
  logic [6:0] cap_t [16] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h0c, 7'h10,
    7'h14, 7'h18, 7'h1c, 7'h20, 7'h24, 7'h28, 7'h2c, 7'h30, 7'h38, 7'h40};
  logic [13:0] rate_t [8] = '{14'h0032, 14'h0064, 14'h00fa, 14'h01f4,
    14'h03e8, 14'h07d0, 14'h1388, 14'h2710};
  logic [12:0] thr_t [18] = '{13'h009c, 13'h0138, 13'h01d4, 13'h0271,
    13'h030d, 13'h03a9, 13'h04e2, 13'h061a, 13'h0753, 13'h08f3, 13'h09c4,
    13'h0b64, 13'h0c35, 13'h0d05, 13'h0ea6, 13'h1046, 13'h11e7, 13'h1388};

  // short divider keeps probe periods for rate codes 5 to 7 to tens of cycles
  msc_startup_config #(.CLK_HZ(PCLK)) msc_startup_config_i (.*);

  always #10 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] resp);
    int   n;
    logic ta, tw, tb;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      // ready is registered, so sample it mid-cycle before the edge
      @(negedge ref_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tb)
        break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40)
    begin
      fail_count++;
      stop_test;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int   n;
    logic ta, tr;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge ref_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (tr)
        break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40)
    begin
      fail_count++;
      stop_test;
    end
  endtask

  task automatic test_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    axi_read(8'h84, d, r);
    chk(d, 32'h0);
    chk(startup_method_onehot, 4'h1);
    chk(align_time_ms, 14'h000a);
    chk(probe_current_threshold, 13'h009c);
    $display("reset test done");
  endtask

  task automatic test_fields;
    logic [31:0] w, d;
    logic [1:0]  r;
    logic [4:0]  c;
    for (int i = 0; i < 18; i++)
    begin
      c = 5'(i);
      w = {1'b1, c[1:0], c[3:0], c[3:0], c[3:0], c[2:0], c, c[0], c[1:0],
           c[1:0], c[3:0]};
      open_loop_current_cap <= 4'hf - c[3:0];
      general_current_cap <= 7'h50 + {2'h0, c};
      axi_write(8'h84, w, 4'hf, r);
      chk(r, 2'h0);
      axi_read(8'h84, d, r);
      chk(d, w & 32'h7fffffff);
      chk(startup_method_onehot, 4'h1 << c[1:0]);
      chk(current_ramp_rate, ramp_t[c[3:0]]);
      chk(current_ramp_unlimited, c[3:0] == 4'hf);
      chk(align_time_ms, align_t[c[3:0]]);
      chk(startup_current_cap, cap_t[c[3:0]]);
      chk(probe_pulse_rate, rate_t[c[2:0]]);
      chk(probe_current_threshold, thr_t[c]);
      chk(probe_release_mode, c[0]);
      chk(probe_advance_angle, {5'h0, c[1:0]} * 7'h1e);
      chk(probe_repeat_count, {1'b0, c[1:0]} + 3'h1);
      chk(open_loop_limit, c[3] ? 7'h50 + c : cap_t[4'hf - c[3:0]]);
      chk({torque_current_rampdown_en, active_brake_en, reverse_profile_sel,
           open_loop_limit_source}, {c[2:0], c[3]});
    end
    $display("field decode test done");
  endtask

  task automatic test_threshold;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 2; i++)
    begin
      axi_write(8'h84, {18'h0, (i ? 5'h1f : 5'h12), 9'h0}, 4'hf, r);
      axi_read(8'h88, d, r);
      chk(d, 32'h1);
      chk(probe_current_threshold, 13'h0000);
      chk(probe_thr_invalid, 1'b1);
    end
    $display("threshold test done");
  endtask

  task automatic test_bus;
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h84, 32'h0, 4'hf, r);
    axi_write(8'h84, 32'hffffffff, 4'h2, r);
    axi_write(8'h84, 32'hffffffff, 4'h8, r);
    axi_write(8'h88, 32'hffffffff, 4'hf, r);
    chk(r, 2'h0);
    axi_write(8'h40, 32'h12345678, 4'hf, r);
    chk(r, 2'h3);
    axi_read(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, 2'h3);
    axi_read(8'h84, d, r);
    chk(d, 32'h7f00ff00);
    $display("bus test done");
  endtask

  task automatic test_probe;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (int i = 5; i < 8; i++)
    begin
      axi_write(8'h84, {15'h0, 3'(i), 14'h0}, 4'hf, r);
      probe_run <= 1'b1;
      axi_read(8'h88, d, r);
      chk(d, 32'h2);
      for (n = 0; n < 300 && probe_tick !== 1'b1; n++)
        @(negedge ref_clk);
      n = 0;
      do
      begin
        @(negedge ref_clk);
        n++;
      end
      while (probe_tick !== 1'b1 && n < 300);
      chk(n, PCLK / rate_t[i]);
      if (n >= 300)
        stop_test;
      @(posedge ref_clk);
      probe_run <= 1'b0;
    end
    $display("probe pulse test done");
  endtask

  initial
  begin
    test_reset;
    test_fields;
    test_threshold;
    test_bus;
    test_probe;
    test_reset;
    stop_test;
  end
endmodule // msc_startup_config_bench

bind msc_startup_config msc_startup_config_props #(.ADDR_W(ADDR_W))
  msc_startup_config_props_i (.*);
